// [logic/pcg_enable_bank.sv]
// Registered clock enables, one per gated peripheral
`timescale 1ns/10ps
module pcg_enable_bank
  import pcg_pkg::*;
#(
  parameter int WIDTH = NUM_GATES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Disable bits and implemented-bit mask
  input wire logic [WIDTH-1:0] disable_i,
  input wire logic [WIDTH-1:0] present_i,
  // Enables toward the peripherals
  output logic [WIDTH-1:0] clk_en_o
);

  typedef struct packed {
    logic [WIDTH-1:0] en;
  } pcg_bank_state_t;

  pcg_bank_state_t bank_q;
  pcg_bank_state_t bank_d;

  // Enable moves only on a rising edge, so a cell never sees a short pulse
  always_comb begin
    bank_d = bank_q;
    bank_d.en = ~disable_i & present_i;
  end

  // Reset clears every enable; present peripherals get their clock from the first edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= '0;
    end else begin
      bank_q <= bank_d;
    end
  end

  assign clk_en_o = bank_q.en;

endmodule // pcg_enable_bank

// [logic/pcg_gate_ctrl.sv]
// Peripheral clock gate controller with Wishbone register access
// How it works
// - Setting a disable bit stops that peripheral's clock, leaving it at minimum power.
// - A gated peripheral's register writes are dropped and its reads are marked invalid.
// - Disable bits reset to zero; clearing a bit restores clock and register access.
// - Analog register: converter bit 0, charge-time bit 8, reference bit 12; comparators bits 0-1.
// - Captures at bits 0-4, compares at 16-20, timers one to five at bits 0-4.
// - Serial bits 0-4, SPI 8-9, I2C 16-17; calendar 0, ref clock 1, parallel 16.
// - Only bits of peripherals present on this variant exist; others read zero.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module pcg_gate_ctrl
  import pcg_pkg::*;
#(
  parameter pcg_bank_t PRESENT = PRESENT_ALL
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Peripheral state seen by the misuse monitor
  input wire logic [NUM_GATES-1:0] periph_on_i,
  input wire logic usb_busy_i,
  // Peripheral register access filter
  input wire logic [NUM_GATES-1:0] periph_sel_i,
  input wire logic periph_we_i,
  output logic [NUM_GATES-1:0] periph_wr_en_o,
  output logic [NUM_GATES-1:0] periph_rd_valid_o,
  // Clock enables toward the peripheral clock cells
  output logic [NUM_GATES-1:0] clk_en_o
);

  typedef struct packed {
    pcg_bank_t gate;
    logic [NUM_REGS-1:0] misuse;
    logic ack;
    logic [31:0] dat;
    logic [NUM_GATES-1:0] wr_en;
    logic [NUM_GATES-1:0] rd_valid;
  } pcg_state_t;

  pcg_state_t q;
  pcg_state_t d;

  logic [NUM_GATES-1:0] gate_flat;
  logic [NUM_GATES-1:0] present_flat;
  logic [NUM_GATES-1:0] busy_flat;
  logic req;
  logic [2:0] idx;

  // Byte address to register index; unmapped gives IDX_NONE
  function automatic logic [2:0] reg_index(input logic [7:0] adr);
    logic [2:0] r;
    case (adr)
      OFF_ANALOG: r = IDX_ANALOG;
      OFF_COMPARATOR: r = IDX_COMPARATOR;
      OFF_CAPCMP: r = IDX_CAPCMP;
      OFF_TIMER: r = IDX_TIMER;
      OFF_SERIAL: r = IDX_SERIAL;
      OFF_MISC: r = IDX_MISC;
      OFF_STATUS: r = IDX_STATUS;
      default: r = IDX_NONE;
    endcase
    return r;
  endfunction

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return m;
  endfunction

  assign gate_flat = q.gate;
  assign present_flat = PRESENT;
  assign req = cyc_i & stb_i & ~q.ack;
  assign idx = reg_index(adr_i);

  // USB busy counts as still running for the misuse monitor
  always_comb begin
    busy_flat = periph_on_i;
    busy_flat[IDX_SERIAL*REG_W + USB_BIT] = periph_on_i[IDX_SERIAL*REG_W + USB_BIT] | usb_busy_i;
  end

  always_comb begin
    logic [NUM_GATES-1:0] newly;
    logic [31:0] clr;
    newly = '0;
    clr = '0;
    d = q;
    d.ack = req;
    d.dat = 32'h0000_0000;
    if (req && we_i) begin
      if (idx < IDX_STATUS) begin
        // Absent bits never store, so they read back as zero
        d.gate[idx] = lane_merge(q.gate[idx], dat_i, sel_i) & PRESENT[idx];
      end else if (idx == IDX_STATUS) begin
        clr = lane_merge(32'h0000_0000, dat_i, sel_i);
        d.misuse = q.misuse & ~clr[NUM_REGS-1:0];
      end
    end
    if (req && !we_i) begin
      if (idx < IDX_STATUS) begin
        d.dat = q.gate[idx];
      end else if (idx == IDX_STATUS) begin
        d.dat = {26'h000_0000, q.misuse};
      end
    end
    // Gating a running peripheral is flagged; a new event beats a same-cycle clear
    newly = d.gate & ~q.gate & busy_flat;
    for (int r = 0; r < NUM_REGS; r++) begin
      if (|newly[r*REG_W +: REG_W]) begin
        d.misuse[r] = 1'b1;
      end
    end
    // Register access only reaches clocked peripherals
    d.wr_en = periph_sel_i & {NUM_GATES{periph_we_i}} & clk_en_o;
    d.rd_valid = periph_sel_i & {NUM_GATES{~periph_we_i}} & clk_en_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q.gate <= {NUM_REGS{GATE_RESET}};
      q.misuse <= STATUS_RESET;
      q.ack <= 1'b0;
      q.dat <= 32'h0000_0000;
      q.wr_en <= '0;
      q.rd_valid <= '0;
    end else begin
      q <= d;
    end
  end

  // Enables are flops one edge behind the disable bits
  pcg_enable_bank #(
    .WIDTH(NUM_GATES)
  ) u_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .disable_i(gate_flat),
    .present_i(present_flat),
    .clk_en_o(clk_en_o)
  );

  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign periph_wr_en_o = q.wr_en;
  assign periph_rd_valid_o = q.rd_valid;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_gate_stops_clock: assert property (1'b1 |=> ((clk_en_o & $past(gate_flat)) == '0))
    else $error("gated peripheral still has a clock enable");

  a_clear_restores: assert property (1'b1 |=> (clk_en_o == ($past(~gate_flat) & present_flat)))
    else $error("clock enable does not follow cleared disable bits");

  a_reset_clear: assert property ($past(rst_i) |-> (gate_flat == '0 && q.misuse == '0))
    else $error("disable bits not zero after reset");

  a_write_blocked: assert property (1'b1 |=> ((periph_wr_en_o & ~$past(clk_en_o)) == '0))
    else $error("write reached a gated peripheral");

  a_read_marked: assert property (
    (periph_sel_i != '0 && !periph_we_i) |=> (periph_rd_valid_o == ($past(periph_sel_i) & $past(clk_en_o))))
    else $error("read validity does not match gating");

  a_analog_layout: assert property (
    (req && we_i && adr_i == OFF_ANALOG && sel_i == 4'hF) |=> (q.gate[0] == ($past(dat_i) & ANALOG_MASK & PRESENT[0])))
    else $error("analog register layout wrong");

  a_comp_layout: assert property (
    (req && we_i && adr_i == OFF_COMPARATOR && sel_i == 4'hF) |=>
      (q.gate[1] == ($past(dat_i) & COMPARATOR_MASK & PRESENT[1])))
    else $error("comparator register layout wrong");

  a_capcmp_layout: assert property (
    (req && we_i && adr_i == OFF_CAPCMP && sel_i == 4'hF) |=> (q.gate[2] == ($past(dat_i) & CAPCMP_MASK & PRESENT[2])))
    else $error("capture compare register layout wrong");

  a_timer_layout: assert property (
    (req && we_i && adr_i == OFF_TIMER && sel_i == 4'hF) |=> (q.gate[3] == ($past(dat_i) & TIMER_MASK & PRESENT[3])))
    else $error("timer register layout wrong");

  a_serial_layout: assert property (
    (req && we_i && adr_i == OFF_SERIAL && sel_i == 4'hF) |=> (q.gate[4] == ($past(dat_i) & SERIAL_MASK & PRESENT[4])))
    else $error("serial register layout wrong");

  a_misc_layout: assert property (
    (req && we_i && adr_i == OFF_MISC && sel_i == 4'hF) |=> (q.gate[5] == ($past(dat_i) & MISC_MASK & PRESENT[5])))
    else $error("misc register layout wrong");

  a_absent_zero: assert property (((gate_flat | clk_en_o) & ~present_flat) == '0)
    else $error("absent peripheral bit is active");

  // Release of reset moves the enables once with no disable change, so that edge is left out
  a_edge_only: assert property (
    ($changed(clk_en_o) && !$past(rst_i, 2)) |-> ($past(gate_flat) != $past(gate_flat, 2)))
    else $error("clock enable moved without a disable change");

  a_misuse_flag: assert property (
    (req && we_i && idx < IDX_STATUS && ((d.gate & ~q.gate & busy_flat) != '0)) |=> q.misuse[$past(idx)])
    else $error("gating a running peripheral not flagged");

  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  a_ack_follows: assert property (req |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  a_dat_idle_zero: assert property (!(req && !we_i) |=> (dat_o == 32'h0000_0000))
    else $error("read data not zero outside a read answer");

  a_unmapped_zero: assert property ((req && !we_i && idx == IDX_NONE) |=> (dat_o == 32'h0000_0000))
    else $error("unmapped read returned data");

  a_readback: assert property ((req && !we_i && idx < IDX_STATUS) |=> (dat_o == q.gate[$past(idx)]))
    else $error("read data does not match disable register");

  a_wr_en_passes: assert property (
    (periph_we_i && ((periph_sel_i & clk_en_o) != '0)) |=> (periph_wr_en_o != '0))
    else $error("write to a clocked peripheral was dropped");

  a_usb_misuse: assert property (
    (req && we_i && idx == IDX_SERIAL && usb_busy_i && !q.gate[IDX_SERIAL][USB_BIT] &&
     d.gate[IDX_SERIAL][USB_BIT]) |=> q.misuse[IDX_SERIAL])
    else $error("gating a busy USB not flagged");

  // Status clear never meets a gating event, since one bus request carries one register
  a_status_clear: assert property (
    (req && we_i && idx == IDX_STATUS && sel_i[0] && dat_i[5:0] == 6'h3F) |=> (q.misuse == '0))
    else $error("status write one did not clear flags");

  c_gate_write: cover property (req && we_i && idx < IDX_STATUS ##1 ack_o ##1 gate_flat != '0);
  c_misuse_seen: cover property ($rose(q.misuse != '0));
  c_blocked_write: cover property (periph_we_i && ((periph_sel_i & ~clk_en_o) != '0));
  c_reenable: cover property ($rose(clk_en_o != '0) ##1 gate_flat == '0);
  c_usb_gated: cover property (req && we_i && idx == IDX_SERIAL && usb_busy_i);

endmodule // pcg_gate_ctrl

// [logic/pcg_pkg.sv]
// Constants and types shared by the peripheral clock gate controller
package pcg_pkg;

  // Register file geometry
  localparam int NUM_REGS = 6;
  localparam int REG_W = 32;
  localparam int NUM_GATES = NUM_REGS * REG_W;

  // Byte offsets on the register bus
  localparam logic [7:0] OFF_ANALOG = 8'h00;
  localparam logic [7:0] OFF_COMPARATOR = 8'h04;
  localparam logic [7:0] OFF_CAPCMP = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0C;
  localparam logic [7:0] OFF_SERIAL = 8'h10;
  localparam logic [7:0] OFF_MISC = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Register indices
  localparam logic [2:0] IDX_ANALOG = 3'h0;
  localparam logic [2:0] IDX_COMPARATOR = 3'h1;
  localparam logic [2:0] IDX_CAPCMP = 3'h2;
  localparam logic [2:0] IDX_TIMER = 3'h3;
  localparam logic [2:0] IDX_SERIAL = 3'h4;
  localparam logic [2:0] IDX_MISC = 3'h5;
  localparam logic [2:0] IDX_STATUS = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // Field positions of the disable bits
  localparam int CONVERTER_BIT = 0;
  localparam int CHARGE_TIME_BIT = 8;
  localparam int COMP_REF_BIT = 12;
  localparam int COMPARATOR_BASE = 0;
  localparam int COMPARATOR_COUNT = 2;
  localparam int CAPTURE_BASE = 0;
  localparam int COMPARE_BASE = 16;
  localparam int UNIT_COUNT = 5;
  localparam int TIMER_BASE = 0;
  localparam int SERIAL_BASE = 0;
  localparam int SPI_BASE = 8;
  localparam int I2C_BASE = 16;
  localparam int PAIR_COUNT = 2;
  localparam int USB_BIT = 24;
  localparam int CALENDAR_BIT = 0;
  localparam int REFCLK_OUT_BIT = 1;
  localparam int PARALLEL_BIT = 16;

  // Implemented bits of each register
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] FIVE_BITS = 32'h0000_001F;
  localparam logic [31:0] TWO_BITS = 32'h0000_0003;
  localparam logic [31:0] ANALOG_MASK = (ONE << CONVERTER_BIT) | (ONE << CHARGE_TIME_BIT) | (ONE << COMP_REF_BIT);
  localparam logic [31:0] COMPARATOR_MASK = TWO_BITS << COMPARATOR_BASE;
  localparam logic [31:0] CAPCMP_MASK = (FIVE_BITS << CAPTURE_BASE) | (FIVE_BITS << COMPARE_BASE);
  localparam logic [31:0] TIMER_MASK = FIVE_BITS << TIMER_BASE;
  localparam logic [31:0] SERIAL_MASK = (FIVE_BITS << SERIAL_BASE) | (TWO_BITS << SPI_BASE) |
                                        (TWO_BITS << I2C_BASE) | (ONE << USB_BIT);
  localparam logic [31:0] MISC_MASK = (ONE << CALENDAR_BIT) | (ONE << REFCLK_OUT_BIT) | (ONE << PARALLEL_BIT);

  // Reset values
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;
  localparam logic [5:0] STATUS_RESET = 6'h00;

  typedef logic [NUM_REGS-1:0][REG_W-1:0] pcg_bank_t;

  localparam pcg_bank_t PRESENT_ALL = {MISC_MASK, SERIAL_MASK, TIMER_MASK, CAPCMP_MASK, COMPARATOR_MASK, ANALOG_MASK};

endpackage

// [sim/tb_top.sv]
// Self-checking bench for the peripheral clock gate controller
`timescale 1ns/10ps
module tb_top;
  import pcg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic ack_o;
  logic [NUM_GATES-1:0] on = '0;
  logic [NUM_GATES-1:0] psel = '0;
  logic [NUM_GATES-1:0] wr_en;
  logic [NUM_GATES-1:0] rd_valid;
  logic [NUM_GATES-1:0] clk_en;
  logic usb_busy = 1'b0;
  logic pwe = 1'b0;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  // Implemented bits per register, index 0 = analog
  logic [31:0] exp_reg [6] = '{32'h0000_1101, 32'h0000_0003, 32'h001F_001F,
                               32'h0000_001F, 32'h0103_031F, 32'h0001_0003};

  always #2.5 clk_i = ~clk_i;

  pcg_gate_ctrl pcg_gate_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .periph_on_i(on), .usb_busy_i(usb_busy),
    .periph_sel_i(psel), .periph_we_i(pwe), .periph_wr_en_o(wr_en), .periph_rd_valid_o(rd_valid),
    .clk_en_o(clk_en)
  );

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard, well above the hundred-odd cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      complete_run;
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [NUM_GATES-1:0] got, input logic [NUM_GATES-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; waits for ack, no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hF, 32'h0000_0000);
    chk_reg(rd, exp);
  endtask

  // Enables lag the register by one edge, the filter by one more
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic note(input string name);
    $display("test %s done, mismatches so far %0d", name, miscompares);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    settle;
    for (int i = 0; i < 6; i++) rdchk(8'(4 * i), 32'h0000_0000);
    chk_vec(clk_en, PRESENT_ALL);
    rdchk(OFF_STATUS, 32'h0000_0000);
    note("reset");
    // Gate everything while capture one is on and USB busy
    on[64] <= 1'b1;
    usb_busy <= 1'b1;
    psel <= '1;
    pwe <= 1'b1;
    for (int i = 0; i < 6; i++) wb(1'b1, 8'(4 * i), 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) rdchk(8'(4 * i), exp_reg[i]);
    settle;
    chk_vec(clk_en, '0);
    chk_vec(wr_en, '0);
    pwe <= 1'b0;
    settle;
    chk_vec(rd_valid, '0);
    rdchk(OFF_STATUS, 32'h0000_0014);
    wb(1'b1, OFF_STATUS, 4'hF, 32'h0000_003F);
    rdchk(OFF_STATUS, 32'h0000_0000);
    note("gate");
    // Clearing restores clocks and register access
    on <= '0;
    usb_busy <= 1'b0;
    for (int i = 0; i < 6; i++) wb(1'b1, 8'(4 * i), 4'hF, 32'h0000_0000);
    settle;
    chk_vec(clk_en, PRESENT_ALL);
    chk_vec(rd_valid, PRESENT_ALL);
    pwe <= 1'b1;
    settle;
    chk_vec(wr_en, PRESENT_ALL);
    note("restore");
    // Single byte lane, then an unmapped address
    wb(1'b1, OFF_SERIAL, 4'b0010, 32'hFFFF_FFFF);
    rdchk(OFF_SERIAL, 32'h0000_0300);
    settle;
    chk_vec(clk_en, PRESENT_ALL ^ (192'h3 << 136));
    wb(1'b1, 8'h1C, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h1C, 32'h0000_0000);
    rdchk(OFF_SERIAL, 32'h0000_0300);
    note("lanes");
    complete_run;
  end
endmodule // tb_top
